//--- include/cfg_bank_pkg.sv
package cfg_bank_pkg;
  // -------------------------------------------------------------------
  // register addresses
  // -------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_LEVEL = 8'h01;
  localparam logic [7:0] ADDR_GAIN_B = 8'h25;
  localparam logic [7:0] ADDR_GAIN_A = 8'h2B;
  localparam logic [7:0] ADDR_GAIN_D = 8'h31;
  localparam logic [7:0] ADDR_GAIN_C = 8'h37;
  localparam logic [7:0] ADDR_ZOFS_A = 8'h3D;
  localparam logic [7:0] ADDR_UCODE_HI = 8'h3F;
  localparam logic [7:0] ADDR_UCODE_LO = 8'h40;
  localparam logic [7:0] ADDR_DIG_ON = 8'h42;
  localparam logic [7:0] ADDR_OVR_PDN = 8'h45;
  localparam logic [7:0] ADDR_SLOW_A = 8'h4A;
  localparam logic [7:0] ADDR_NOISE_A = 8'h58;
  localparam logic [7:0] ADDR_ONE_A = 8'h59;
  localparam logic [7:0] ADDR_SLOW_B = 8'h62;
  localparam logic [7:0] ADDR_NOISE_B = 8'h70;
  localparam logic [7:0] ADDR_ONE_B = 8'h71;
  localparam logic [7:0] ADDR_SLOW_D = 8'h7A;
  localparam logic [7:0] ADDR_NOISE_D = 8'h88;
  localparam logic [7:0] ADDR_ONE_D = 8'h89;
  localparam logic [7:0] ADDR_SLOW_C = 8'h92;
  localparam logic [7:0] ADDR_NOISE_C = 8'hA0;
  localparam logic [7:0] ADDR_ONE_C = 8'hA1;
  localparam logic [7:0] ADDR_CLKDLY_1 = 8'hA9;
  localparam logic [7:0] ADDR_CLKDLY_2 = 8'hAC;
  localparam logic [7:0] ADDR_QOVR_LVL = 8'hC3;
  localparam logic [7:0] ADDR_QOVR_ON = 8'hC4;
  localparam logic [7:0] ADDR_ZOFS_B = 8'hCF;
  localparam logic [7:0] ADDR_ONE_MA = 8'hD6;
  localparam logic [7:0] ADDR_ONE_MB = 8'hD7;
  localparam logic [7:0] ADDR_FREQ_KEY = 8'hF1;
  localparam logic [7:0] ADDR_SLEEP = 8'hFE;
  // -------------------------------------------------------------------
  // fields, masks, reset values
  // -------------------------------------------------------------------
  localparam int NUM_REGS = 32;
  localparam int BIT_READBACK = 0;
  localparam int BIT_SOFT_RESET = 1;
  localparam int LEVEL_LSB = 2;
  localparam int LEVEL_W = 6;
  localparam int KEY_LSB = 0;
  localparam logic [1:0] KEY_OPEN = 2'h3;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] MASK_CONTROL = 8'h03;
  localparam logic [5:0] LEVEL_350 = 6'h00;
  localparam logic [5:0] LEVEL_420 = 6'h1B;
  localparam logic [5:0] LEVEL_470 = 6'h32;
  localparam logic [5:0] LEVEL_560 = 6'h14;
  localparam logic [5:0] LEVEL_160 = 6'h0F;
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS = 8;
  // -------------------------------------------------------------------
  // output level selections
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {SWING_350, SWING_420, SWING_470, SWING_560, SWING_160}
    swing_e;
  // -------------------------------------------------------------------
  // map tables
  // -------------------------------------------------------------------
  localparam logic [7:0] MAP_ADDR [NUM_REGS] = '{
    ADDR_CONTROL, ADDR_LEVEL, ADDR_GAIN_B, ADDR_GAIN_A, ADDR_GAIN_D, ADDR_GAIN_C,
    ADDR_ZOFS_A, ADDR_UCODE_HI, ADDR_UCODE_LO, ADDR_DIG_ON, ADDR_OVR_PDN,
    ADDR_SLOW_A, ADDR_NOISE_A, ADDR_ONE_A, ADDR_SLOW_B, ADDR_NOISE_B, ADDR_ONE_B,
    ADDR_SLOW_D, ADDR_NOISE_D, ADDR_ONE_D, ADDR_SLOW_C, ADDR_NOISE_C, ADDR_ONE_C,
    ADDR_CLKDLY_1, ADDR_CLKDLY_2, ADDR_QOVR_LVL, ADDR_QOVR_ON, ADDR_ZOFS_B,
    ADDR_ONE_MA, ADDR_ONE_MB, ADDR_FREQ_KEY, ADDR_SLEEP};
  localparam logic [7:0] MAP_MASK [NUM_REGS] = '{
    MASK_CONTROL, 8'hFC, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h20, 8'h3F, 8'hFF, 8'h08,
    8'h1D, 8'h01, 8'h20, 8'h80, 8'h01, 8'h20, 8'h80, 8'h01, 8'h20, 8'h80, 8'h01,
    8'h20, 8'h80, 8'h0F, 8'h79, 8'hFF, 8'h80, 8'h08, 8'h80, 8'h0C, 8'h23, 8'h0F};
endpackage

//--- include/frame_if.sv
`timescale 1ns/100ps
interface frame_if;
  logic [7:0] addr;
  logic [7:0] data;
  logic toggle;
  modport src (output addr, output data, output toggle);
  modport dst (input addr, input data, input toggle);
endinterface

//--- rtl/cfg_register_bank.sv
`timescale 1ns/100ps
module cfg_register_bank
  import cfg_bank_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic hw_reset_i,
  input wire logic sclk_i,
  input wire logic serial_select_n_i,
  input wire logic serial_write_in_i,
  output logic serial_read_out_o,
  output logic serial_read_oe_o,
  output cfg_bank_pkg::swing_e swing_o,
  output logic [5:0] level_code_o,
  output logic readback_o,
  output logic [7:0] gain_first_o,
  output logic zero_offset_on_a_o,
  output logic [13:0] user_code_o,
  output logic [3:0] sleep_o,
  output logic [1:0] output_level_key_o
);
  import cfg_bank_pkg::*;

  frame_if link ();
  logic [7:0] regs_reg [NUM_REGS];
  logic [7:0] regs_next [NUM_REGS];
  logic [2:0] tog_sync_reg;
  logic [1:0] hw_sync_reg;
  logic hw_catch_reg;
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  logic [7:0] data_reg;
  logic wr_pulse;
  logic soft_reset;
  logic [7:0] read_value;

  // -------------------------------------------------------------------
  // map lookup
  // -------------------------------------------------------------------
  function automatic int find_index(input logic [7:0] addr);
    int idx;
    idx = -1;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      if (MAP_ADDR[i] == addr)
      begin
        idx = i;
      end
    end
    return idx;
  endfunction

  // -------------------------------------------------------------------
  // link side
  // -------------------------------------------------------------------
  serial_frame_rx u_rx (
    .sclk_i(sclk_i),
    .link_resetn_i(resetn_i),
    .serial_select_n_i(serial_select_n_i),
    .serial_write_in_i(serial_write_in_i),
    .read_data_i(read_value),
    .serial_read_out_o(serial_read_out_o),
    .frame(link.src)
  );

  // -------------------------------------------------------------------
  // crossings
  // -------------------------------------------------------------------
  // short pin pulse caught asynchronously, held until seen
  always_ff @(posedge mclk_i or posedge hw_reset_i)
  begin
    if (hw_reset_i)
    begin
      hw_catch_reg <= 1'b1;
    end
    else if (clk_en_i)
    begin
      hw_catch_reg <= 1'b0;
    end
  end
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      tog_sync_reg <= 3'h0;
      hw_sync_reg <= 2'h0;
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      data_reg <= 8'h00;
    end
    else if (clk_en_i)
    begin
      tog_sync_reg <= {tog_sync_reg[1:0], link.toggle};
      hw_sync_reg <= {hw_sync_reg[0], hw_catch_reg};
      wr_pend_reg <= tog_sync_reg[2] != tog_sync_reg[1];
      if (tog_sync_reg[2] != tog_sync_reg[1])
      begin
        addr_reg <= link.addr;
        data_reg <= link.data;
      end
    end
  end
  assign wr_pulse = clk_en_i && wr_pend_reg;

  // -------------------------------------------------------------------
  // register update
  // -------------------------------------------------------------------
  assign soft_reset = regs_reg[0][BIT_SOFT_RESET];
  always_comb
  begin
    int idx;
    idx = find_index(addr_reg);
    for (int i = 0; i < NUM_REGS; i++)
    begin
      regs_next[i] = regs_reg[i];
    end
    if (wr_pulse && idx >= 0)
    begin
      if (idx == 0 || !regs_reg[0][BIT_READBACK])
      begin
        regs_next[idx] = data_reg & MAP_MASK[idx];
      end
    end
  end
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        regs_reg[i] <= RESET_VALUE;
      end
    end
    else if (clk_en_i)
    begin
      if (hw_sync_reg[1] || soft_reset)
      begin
        for (int i = 0; i < NUM_REGS; i++)
        begin
          regs_reg[i] <= RESET_VALUE;
        end
      end
      else
      begin
        for (int i = 0; i < NUM_REGS; i++)
        begin
          regs_reg[i] <= regs_next[i];
        end
      end
    end
  end

  // -------------------------------------------------------------------
  // readback
  // -------------------------------------------------------------------
  always_comb
  begin
    int idx;
    idx = find_index(link.addr);
    read_value = 8'h00;
    if (idx > 0)
    begin
      read_value = regs_reg[idx];
    end
  end
  assign serial_read_oe_o = regs_reg[0][BIT_READBACK];

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  level_decode u_level (
    .code_i(regs_reg[1][7:2]),
    .key_i(regs_reg[30][1:0]),
    .swing_o(swing_o)
  );
  assign level_code_o = regs_reg[1][7:2];
  assign readback_o = regs_reg[0][BIT_READBACK];
  assign gain_first_o = regs_reg[3];
  assign zero_offset_on_a_o = regs_reg[6][5];
  assign user_code_o = {regs_reg[7][5:0], regs_reg[8]};
  assign sleep_o = regs_reg[31][3:0];
  assign output_level_key_o = regs_reg[30][1:0];

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  chk_soft_clear: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    soft_reset && clk_en_i |=> !soft_reset)
    else $error("soft reset bit stuck");
  chk_readback_drive: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    serial_read_oe_o == regs_reg[0][0])
    else $error("readback enable wrong");
  chk_swing_key: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    regs_reg[30][1:0] != KEY_OPEN |-> swing_o == SWING_350)
    else $error("key ignored");
  chk_offset_mask: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (regs_reg[6] & 8'hDF) == 8'h00)
    else $error("offset reserved set");
  chk_lock_write: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    regs_reg[0][0] && !soft_reset && !hw_sync_reg[1] |=> $stable(regs_reg[1]))
    else $error("write while locked");
  chk_hw_reset: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    hw_sync_reg[1] && clk_en_i |=> regs_reg[1] == 8'h00)
    else $error("hw reset missed");
  chk_ctrl_hidden: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    find_index(link.addr) == 0 |-> read_value == 8'h00)
    else $error("control read");
  chk_level_mask: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    regs_reg[1][1:0] == 2'h0)
    else $error("reserved level bits");
  chk_level_write: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    wr_pulse && addr_reg == ADDR_LEVEL && !regs_reg[0][0] && !soft_reset && !hw_sync_reg[1]
    |=> regs_reg[1] == $past(data_reg & 8'hFC))
    else $error("level write lost");
  cov_write: cover property (@(posedge mclk_i) wr_pulse);
  cov_swing: cover property (@(posedge mclk_i) swing_o == SWING_420);
  cov_soft: cover property (@(posedge mclk_i) soft_reset);
  cov_hw: cover property (@(posedge mclk_i) hw_sync_reg[1]);
endmodule // cfg_register_bank

//--- rtl/level_decode.sv
`timescale 1ns/100ps
module level_decode
  import cfg_bank_pkg::*;
(
  input wire logic [5:0] code_i,
  input wire logic [1:0] key_i,
  output swing_e swing_o
);
  always_comb
  begin
    swing_o = SWING_350;
    if (key_i == KEY_OPEN)
    begin
      case (code_i)
        LEVEL_420: swing_o = SWING_420;
        LEVEL_470: swing_o = SWING_470;
        LEVEL_560: swing_o = SWING_560;
        LEVEL_160: swing_o = SWING_160;
        default: swing_o = SWING_350;
      endcase
    end
  end
endmodule // level_decode

//--- rtl/serial_frame_rx.sv
`timescale 1ns/100ps
module serial_frame_rx
  import cfg_bank_pkg::*;
(
  input wire logic sclk_i,
  input wire logic link_resetn_i,
  input wire logic serial_select_n_i,
  input wire logic serial_write_in_i,
  input wire logic [7:0] read_data_i,
  output logic serial_read_out_o,
  frame_if.src frame
);
  logic [3:0] count_reg;
  logic [14:0] shift_reg;
  logic [7:0] out_shift_reg;
  logic toggle_reg;
  // -------------------------------------------------------------------
  // shift on falling edge, frame every 16 bits
  // -------------------------------------------------------------------
  always_ff @(negedge sclk_i or posedge serial_select_n_i)
  begin
    if (serial_select_n_i)
    begin
      count_reg <= 4'h0;
    end
    else
    begin
      count_reg <= count_reg + 4'h1;
    end
  end
  always_ff @(negedge sclk_i)
  begin
    if (!serial_select_n_i)
    begin
      shift_reg <= {shift_reg[13:0], serial_write_in_i};
      if (count_reg == 4'hF)
      begin
        frame.addr <= shift_reg[14:7];
        frame.data <= {shift_reg[6:0], serial_write_in_i};
      end
    end
  end
  always_ff @(negedge sclk_i or negedge link_resetn_i)
  begin
    if (!link_resetn_i)
    begin
      toggle_reg <= 1'b0;
    end
    else if (!serial_select_n_i && count_reg == 4'hF)
    begin
      toggle_reg <= ~toggle_reg;
    end
  end
  assign frame.toggle = toggle_reg;
  // -------------------------------------------------------------------
  // readback data on rising edge in data phase
  // -------------------------------------------------------------------
  always_ff @(posedge sclk_i)
  begin
    if (count_reg == 4'h8)
    begin
      out_shift_reg <= {read_data_i[6:0], 1'b0};
      serial_read_out_o <= read_data_i[7];
    end
    else
    begin
      out_shift_reg <= {out_shift_reg[6:0], 1'b0};
      serial_read_out_o <= out_shift_reg[7];
    end
  end
endmodule // serial_frame_rx

//--- verif/adc_config_register_bank_test.sv
`timescale 1ns/100ps
module adc_config_register_bank_test;
  import cfg_bank_pkg::*;
  logic mclk_i, resetn_i, hw_reset_i, sdo, oe, rb, zofs;
  logic clk_en;
  wire logic sclk, sel_n, sdin, sdo_pin;
  swing_e swing;
  logic [5:0] lvl;
  logic [7:0] gain, rd, r;
  logic [13:0] ucode;
  logic [3:0] slp;
  logic [1:0] key;
  logic [7:0] m [256];
  int num_errors = 0;
  int check_count = 0;
  integer seed = 32'h81FE9BAB;
  assign sdo_pin = oe ? sdo : 1'bz;
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  serial_host_model host (.sclk_o(sclk), .select_n_o(sel_n), .serial_write_in_o(sdin), .sdo_i(sdo_pin));
  cfg_register_bank i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .clk_en_i(clk_en),
    .hw_reset_i(hw_reset_i), .sclk_i(sclk), .serial_select_n_i(sel_n),
    .serial_write_in_i(sdin), .serial_read_out_o(sdo), .serial_read_oe_o(oe),
    .swing_o(swing), .level_code_o(lvl), .readback_o(rb), .gain_first_o(gain),
    .zero_offset_on_a_o(zofs), .user_code_o(ucode), .sleep_o(slp),
    .output_level_key_o(key));
  // -------------------------------------------------------------------
  // model and compares
  // -------------------------------------------------------------------
  function automatic logic [7:0] msk(input logic [7:0] a);
    msk = 8'h00;
    for (int i = 0; i < NUM_REGS; i++)
      if (MAP_ADDR[i] == a) msk = MAP_MASK[i];
  endfunction
  function automatic swing_e exp_sw();
    exp_sw = SWING_350;
    if (m[8'hF1][1:0] == 2'h3)
    begin
      case (m[8'h01][7:2])
        LEVEL_420: exp_sw = SWING_420;
        LEVEL_470: exp_sw = SWING_470;
        LEVEL_560: exp_sw = SWING_560;
        LEVEL_160: exp_sw = SWING_160;
        default: exp_sw = SWING_350;
      endcase
    end
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  task automatic chk_sw(input swing_e e);
    check_count++;
    if (swing !== e)
    begin
      $display("unexpected swing: expected %s seen %s", e.name(), swing.name());
      num_errors++;
    end
  endtask
  task automatic cmp_all();
    chk("level", {10'h0, m[8'h01][7:2]}, {10'h0, lvl});
    chk("readback", {15'h0, m[8'h00][0]}, {15'h0, rb});
    chk("gain", {8'h0, m[8'h2B]}, {8'h0, gain});
    chk("offset", {15'h0, m[8'h3D][5]}, {15'h0, zofs});
    chk("ucode", {2'h0, m[8'h3F][5:0], m[8'h40]}, {2'h0, ucode});
    chk("sleep", {12'h0, m[8'hFE][3:0]}, {12'h0, slp});
    chk("key", {14'h0, m[8'hF1][1:0]}, {14'h0, key});
    chk_sw(exp_sw());
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.frame(a, d, rd);
    if (a == 8'h00 && d[1]) m = '{default: 8'h00};
    else if (!m[8'h00][0] || a == 8'h00) m[a] = d & msk(a);
    repeat (8) @(negedge mclk_i);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #3000000;
    num_errors++;
    close_out();
  end
  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial
  begin
    m = '{default: 8'h00};
    resetn_i = 1'b0;
    hw_reset_i = 1'b0;
    clk_en = 1'b1;
    repeat (10) @(negedge mclk_i);
    resetn_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    cmp_all();
    $display("test reset done");
    for (int i = 0; i < 12; i++)
    begin
      wr(MAP_ADDR[2 + ($random(seed) & 15)], 8'($random(seed)));
      wr(8'h02 + 8'(i * 5), 8'hFF);
      cmp_all();
    end
    $display("test random writes done");
    wr(8'h01, {LEVEL_420, 2'h3});
    cmp_all();
    wr(8'hF1, 8'h03);
    for (int k = 0; k < 5; k++)
    begin
      wr(8'h01, {(k == 0) ? LEVEL_420 : (k == 1) ? LEVEL_470 : (k == 2) ? LEVEL_560 :
        (k == 3) ? LEVEL_160 : LEVEL_350, 2'h0});
      cmp_all();
    end
    $display("test swing done");
    wr(8'hFE, 8'($random(seed)) | 8'h01);
    cmp_all();
    r = ~m[8'h2B];
    clk_en = 1'b0;
    host.frame(8'h2B, r, rd);
    repeat (8) @(negedge mclk_i);
    chk("frozen", {8'h0, m[8'h2B]}, {8'h0, gain});
    clk_en = 1'b1;
    repeat (8) @(negedge mclk_i);
    m[8'h2B] = r;
    cmp_all();
    $display("test freeze done");
    r = 8'($random(seed));
    wr(8'h59, 8'h80);
    wr(8'h2B, r);
    wr(8'h00, 8'h01);
    chk("oe", 16'h1, {15'h0, oe});
    wr(8'h2B, ~r);
    cmp_all();
    wr(8'h2B, 8'h00);
    wr(8'h2B, 8'h00);
    chk("sdout", {8'h0, r}, {8'h0, rd});
    wr(8'h59, 8'h00);
    wr(8'h59, 8'h00);
    chk("sdout", 16'h80, {8'h0, rd});
    wr(8'h00, 8'h01);
    wr(8'h00, 8'h01);
    chk("sdout", 16'h0, {8'h0, rd});
    wr(8'h00, 8'h00);
    chk("oe", 16'h0, {15'h0, oe});
    $display("test readback done");
    wr(8'h2B, 8'($random(seed)));
    wr(8'h00, 8'h03);
    cmp_all();
    $display("test soft reset done");
    wr(8'h40, 8'($random(seed)) | 8'h01);
    hw_reset_i = 1'b1;
    #12;
    hw_reset_i = 1'b0;
    repeat (6) @(negedge mclk_i);
    m = '{default: 8'h00};
    cmp_all();
    $display("test hardware reset done");
    close_out();
  end
endmodule // adc_config_register_bank_test

//--- verif/serial_host_model.sv
`timescale 1ns/100ps
module serial_host_model (
  output logic sclk_o,
  output logic select_n_o,
  output logic serial_write_in_o,
  input wire logic sdo_i
);
  initial
  begin
    sclk_o = 1'b0;
    select_n_o = 1'b1;
    serial_write_in_o = 1'b0;
  end
  // -------------------------------------------------------------------
  // one frame, address then data, msb first
  // -------------------------------------------------------------------
  task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic [7:0] rd);
    logic [15:0] w;
    w = {a, d};
    if (a == 8'h00) w[7:2] = 6'h00;
    if (a == 8'h01) w[1:0] = 2'h0;
    #3.1 select_n_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      serial_write_in_o = w[i];
      #3.75 sclk_o = 1'b1;
      #7.5 sclk_o = 1'b0;
      if (i < 8) rd[i] = sdo_i;
      #3.75;
    end
    #7.5 select_n_o = 1'b1;
    serial_write_in_o = ~serial_write_in_o;
  endtask
endmodule // serial_host_model
